/* src/monitor_host_port_pkg.sv */
/*
  Constants for the host register port of the hardware monitor: index map,
  power-on defaults, configuration bit positions and the reset pulse timing.
  Assumes a single 50 MHz clock.
*/
// Summary of operation
// - pointer port holds a 7-bit index selecting the data-port location
// - pointer bit 7 reads one while the device is busy
// - busy sets on a pointer write and during a serial transaction
// - data access clears pointer busy; serial busy ends with transaction
// - after power-on the index is 00h and busy is zero
// - registers sit at indices 40h to 49h as fixed map
// - access at 41h, 43h or 45h steps pointer to the paired register
// - boot-code window 00-1Fh steps per access, holding at 1Fh
// - value RAM at 20-3Fh and 60-7Fh; upper window steps to 7Fh
// - data port moves one byte to or from the selected location
// - configuration resets to 08h: interrupt clear set, monitoring off
// - configuration bit 0 runs monitoring, zero means standby
// - clearing start leaves interrupt pins asserted
// - bit 1 enables management interrupt, bit 2 host interrupt
// - bit 3 deasserts both interrupts and halts monitoring
// - bit 4 pulses reset low 20 ms if enabled, then self-clears
// - bit 5 selects non-maskable or ordinary host interrupt
// - bit 6 drives open-drain bypass output low
// - bit 7 reloads defaults except slave address, reads zero
// - index 49h: bit 0 is voltage id bit four, upper bits identity
// - capture port writes use their own boot-code pointer
// - second serial mask bit 7 enables the reset pulse
package monitor_host_port_pkg;
  // -------------------------------------------------------------------------
  // index map
  // -------------------------------------------------------------------------
  localparam logic [6:0] IDX_CONFIG = 7'h40;
  localparam logic [6:0] IDX_STAT_ONE = 7'h41;
  localparam logic [6:0] IDX_STAT_TWO = 7'h42;
  localparam logic [6:0] IDX_SMASK_ONE = 7'h43;
  localparam logic [6:0] IDX_SMASK_TWO = 7'h44;
  localparam logic [6:0] IDX_HMASK_ONE = 7'h45;
  localparam logic [6:0] IDX_HMASK_TWO = 7'h46;
  localparam logic [6:0] IDX_FAN_DIV = 7'h47;
  localparam logic [6:0] IDX_SLAVE_ADDR = 7'h48;
  localparam logic [6:0] IDX_IDENT = 7'h49;
  localparam logic [6:0] IDX_BOOT_LAST = 7'h1f;
  localparam logic [6:0] IDX_VALUE_LAST = 7'h7f;
  // -------------------------------------------------------------------------
  // power-on defaults
  // -------------------------------------------------------------------------
  localparam logic [7:0] CONFIG_RST = 8'h08;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] HMASK_TWO_RST = 8'h40;
  localparam logic [3:0] FAN_DIV_RST = 4'h5;
  localparam logic [7:0] SLAVE_ADDR_RST = 8'h2d;
  localparam logic [6:0] INDEX_RST = 7'h00;
  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int CFG_START = 0;
  localparam int CFG_SMI_EN = 1;
  localparam int CFG_HOST_EN = 2;
  localparam int CFG_IRQ_CLR = 3;
  localparam int CFG_RESET = 4;
  localparam int CFG_NMI_SEL = 5;
  localparam int CFG_BYPASS = 6;
  localparam int CFG_DEFAULTS = 7;
  localparam int SMASK2_RST_EN = 7;
  localparam int STAT2_OVERFLOW = 5;
  localparam int PTR_BUSY = 7;
  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam longint CLK_HZ = 50000000;
  localparam longint RESET_PULSE_MS = 20;
  localparam longint RESET_PULSE_CYCLES = (CLK_HZ * RESET_PULSE_MS + 999) / 1000;
endpackage : monitor_host_port_pkg

/* src/pin_sync.sv */
/*
  Three-stage synchroniser for a group of pin levels. A new level is taken
  only once stages two and three agree. Assumes asynchronous pin inputs.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pins in, filtered levels out
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] levelOut
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  // shift chain; stage one is read only by stage two
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pinIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.level = (st_r.s2 & st_r.s3) | (st_r.level & (st_r.s2 | st_r.s3));
    if (sys_rst) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign levelOut = st_r.level;
endmodule : pin_sync

/* src/pulse_timer.sv */
/*
  One-shot timer: a start pulse raises active for CYCLES clocks, then a done
  pulse follows. Starts while running are ignored.
*/
`timescale 1ns/1ns
module pulse_timer #(
  parameter int CYCLES = 1000000
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic start,
  output logic active,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef enum logic [0:0] {
    T_IDLE = 1'b0,
    T_RUN = 1'b1
  } tstate_t;

  typedef struct packed {
    tstate_t state;
    logic [CW-1:0] count;
    logic done;
  } timer_t;

  timer_t st_r;
  timer_t st_nxt;

  // idle waits for start, run counts to the last cycle
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    case (st_r.state)
      T_IDLE: begin
        if (start) begin
          st_nxt.state = T_RUN;
          st_nxt.count = '0;
        end
      end
      T_RUN: begin
        if (st_r.count == LAST) begin
          st_nxt.state = T_IDLE;
          st_nxt.done = 1'b1;
        end else begin
          st_nxt.count = st_r.count + CW'(1);
        end
      end
      default: st_nxt.state = T_IDLE;
    endcase
    if (sys_rst) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign active = (st_r.state == T_RUN);
  assign done = st_r.done;
endmodule : pulse_timer

/* src/monitor_host_port_config.sv */
/*
  Host register port and configuration register of the hardware monitor:
  index pointer with busy flag, data window, paired and RAM auto-increment,
  boot-code capture RAM, value RAM, interrupt outputs and reset pulse.
  Assumes host strobes are one-cycle pulses on clk from the bus front end,
  and that the monitoring loop and serial slave sit outside.
*/
`timescale 1ns/1ns
module monitor_host_port_config
  import monitor_host_port_pkg::*;
#(
  parameter longint RESET_CYCLES = RESET_PULSE_CYCLES,
  parameter logic [6:0] DEVICE_ID = 7'h2a // arbitrary identity value
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host port: portSel 0 = index pointer, 1 = data window
  input wire logic hostWrStb,
  input wire logic hostRdStb,
  input wire logic hostPortSel,
  input wire logic [7:0] hostWrData,
  output logic [7:0] hostRdData,
  // boot-code capture port
  input wire logic bootCodeWrStb,
  input wire logic [7:0] bootCodeData,
  // monitoring loop and serial slave side
  input wire logic serialBusy,
  input wire logic [7:0] statusSetOne,
  input wire logic [6:0] statusSetTwo,
  output logic monitorRun,
  output logic [7:0] serialSlaveAddr,
  output logic [3:0] fanDivisor,
  // voltage id pins
  input wire logic [4:0] voltageIdPins,
  // interrupt pins, active low; nmiSelect is high for non-maskable
  output logic sysMgmtInterruptOut_n,
  output logic hostIrqOut_n,
  output logic nmiSelect,
  // open-drain reset and bypass pins
  output logic resetPinOut,
  output logic resetPinOe,
  output logic bypassPinOut,
  output logic bypassPinOe
);
  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [6:0] indexBits;
    logic busyByPtr;
    logic [7:0] rdData;
    logic [7:0] cfg;
    logic [7:0] statOne;
    logic [7:0] statTwo;
    logic [7:0] smaskOne;
    logic [7:0] smaskTwo;
    logic [7:0] hmaskOne;
    logic [7:0] hmaskTwo;
    logic [3:0] fanDiv;
    logic [7:0] slaveAddr;
    logic [4:0] capturePtr;
    logic captureFull;
    logic [31:0][7:0] bootRam;
    logic [63:0][7:0] valueRam;
    logic pulseStarted;
    logic timerStart;
    logic resetOe;
    logic bypassOe;
    logic smiOut_n;
    logic hostOut_n;
    logic nmiSel;
    logic run;
  } port_t;

  port_t st_r;
  port_t st_nxt;

  logic [4:0] voltageId;
  logic timerActive;
  logic timerDone;

  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  // boot-code window test
  function automatic logic isBootRam(input logic [6:0] idx);
    return idx <= IDX_BOOT_LAST;
  endfunction : isBootRam

  // either value RAM window
  function automatic logic isValueRam(input logic [6:0] idx);
    return idx[5];
  endfunction : isValueRam

  // value RAM address folds both windows into 64 bytes
  function automatic logic [5:0] valueAddr(input logic [6:0] idx);
    return {idx[6], idx[4:0]};
  endfunction : valueAddr

  // pointer after a data access
  function automatic logic [6:0] stepIndex(input logic [6:0] idx);
    logic [6:0] res;
    res = idx;
    if (idx == IDX_STAT_ONE || idx == IDX_SMASK_ONE ||
        idx == IDX_HMASK_ONE) begin
      res = idx + 7'h01;
    end else if (isBootRam(idx)) begin
      if (idx != IDX_BOOT_LAST) begin
        res = idx + 7'h01;
      end
    end else if (idx[6:5] == 2'b11) begin
      if (idx != IDX_VALUE_LAST) begin
        res = idx + 7'h01;
      end
    end
    return res;
  endfunction : stepIndex

  // -------------------------------------------------------------------------
  // pins and reset pulse timer
  // -------------------------------------------------------------------------
  pin_sync #(
    .WIDTH(5)
  ) u_vid_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pinIn(voltageIdPins),
    .levelOut(voltageId)
  );

  pulse_timer #(
    .CYCLES(int'(RESET_CYCLES))
  ) u_reset_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(st_r.timerStart),
    .active(timerActive),
    .done(timerDone)
  );

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb begin
    logic dataAcc;
    logic [7:0] rdByte;
    logic [7:0] pend1;
    logic [7:0] pend2;
    dataAcc = 1'b0;
    rdByte = 8'h00;
    pend1 = 8'h00;
    pend2 = 8'h00;
    st_nxt = st_r;
    st_nxt.timerStart = 1'b0;
    dataAcc = hostPortSel && (hostWrStb || hostRdStb);

    // read mux for the data window
    if (isBootRam(st_r.indexBits)) begin
      rdByte = st_r.bootRam[st_r.indexBits[4:0]];
    end else if (isValueRam(st_r.indexBits)) begin
      rdByte = st_r.valueRam[valueAddr(st_r.indexBits)];
    end else if (st_r.indexBits == IDX_CONFIG) begin
      rdByte = st_r.cfg;
    end else if (st_r.indexBits == IDX_STAT_ONE) begin
      rdByte = st_r.statOne;
    end else if (st_r.indexBits == IDX_STAT_TWO) begin
      rdByte = st_r.statTwo;
    end else if (st_r.indexBits == IDX_SMASK_ONE) begin
      rdByte = st_r.smaskOne;
    end else if (st_r.indexBits == IDX_SMASK_TWO) begin
      rdByte = st_r.smaskTwo;
    end else if (st_r.indexBits == IDX_HMASK_ONE) begin
      rdByte = st_r.hmaskOne;
    end else if (st_r.indexBits == IDX_HMASK_TWO) begin
      rdByte = st_r.hmaskTwo;
    end else if (st_r.indexBits == IDX_FAN_DIV) begin
      rdByte = {st_r.fanDiv, voltageId[3:0]};
    end else if (st_r.indexBits == IDX_SLAVE_ADDR) begin
      rdByte = st_r.slaveAddr;
    end else if (st_r.indexBits == IDX_IDENT) begin
      rdByte = {DEVICE_ID, voltageId[4]};
    end else begin
      rdByte = 8'h00; // unmapped reads as zero
    end

    // host reads: pointer port shows busy in bit 7
    if (hostRdStb && !hostPortSel) begin
      st_nxt.rdData = {st_r.busyByPtr | serialBusy,
                       st_r.indexBits};
    end else if (hostRdStb) begin
      st_nxt.rdData = rdByte;
    end

    // pointer write sets busy, data access clears it
    if (hostWrStb && !hostPortSel) begin
      st_nxt.indexBits = hostWrData[6:0];
      st_nxt.busyByPtr = 1'b1;
    end else if (dataAcc) begin
      st_nxt.busyByPtr = 1'b0;
      st_nxt.indexBits = stepIndex(st_r.indexBits);
    end

    // status registers clear on read, new events win
    if (hostRdStb && hostPortSel && st_r.indexBits == IDX_STAT_ONE) begin
      st_nxt.statOne = 8'h00;
    end
    if (hostRdStb && hostPortSel && st_r.indexBits == IDX_STAT_TWO) begin
      st_nxt.statTwo = 8'h00;
    end
    pend1 = statusSetOne;
    pend2 = {1'b0, statusSetTwo};

    // boot-code capture with its own pointer
    if (bootCodeWrStb) begin
      st_nxt.bootRam[st_r.capturePtr] = bootCodeData;
      if (st_r.capturePtr == IDX_BOOT_LAST[4:0]) begin
        st_nxt.captureFull = 1'b1;
        pend2[STAT2_OVERFLOW] = 1'b1;
      end else begin
        st_nxt.capturePtr = st_r.capturePtr + 5'h01;
      end
    end
    st_nxt.statOne = st_nxt.statOne | pend1;
    st_nxt.statTwo = st_nxt.statTwo | pend2;

    // host data writes; status and identity are read only
    if (hostWrStb && hostPortSel) begin
      if (isBootRam(st_r.indexBits)) begin
        st_nxt.bootRam[st_r.indexBits[4:0]] = hostWrData;
      end else if (isValueRam(st_r.indexBits)) begin
        st_nxt.valueRam[valueAddr(st_r.indexBits)] = hostWrData;
      end else if (st_r.indexBits == IDX_CONFIG) begin
        st_nxt.cfg = hostWrData;
        st_nxt.cfg[CFG_DEFAULTS] = 1'b0;
        if (!hostWrData[CFG_RESET]) begin
          st_nxt.pulseStarted = 1'b0;
        end
      end else if (st_r.indexBits == IDX_SMASK_ONE) begin
        st_nxt.smaskOne = hostWrData;
      end else if (st_r.indexBits == IDX_SMASK_TWO) begin
        st_nxt.smaskTwo = hostWrData;
      end else if (st_r.indexBits == IDX_HMASK_ONE) begin
        st_nxt.hmaskOne = hostWrData;
      end else if (st_r.indexBits == IDX_HMASK_TWO) begin
        st_nxt.hmaskTwo = hostWrData;
      end else if (st_r.indexBits == IDX_FAN_DIV) begin
        st_nxt.fanDiv = hostWrData[7:4];
      end else if (st_r.indexBits == IDX_SLAVE_ADDR) begin
        st_nxt.slaveAddr = hostWrData;
      end
    end

    // reset pulse starts once when requested and enabled
    if (st_r.cfg[CFG_RESET] && st_r.smaskTwo[SMASK2_RST_EN] &&
        !st_r.pulseStarted && !timerActive) begin
      st_nxt.timerStart = 1'b1;
      st_nxt.pulseStarted = 1'b1;
    end
    st_nxt.resetOe = timerActive;
    if (timerDone) begin
      st_nxt.cfg[CFG_RESET] = 1'b0;
      st_nxt.pulseStarted = 1'b0;
    end

    // soft reload of defaults, slave address kept
    if (hostWrStb && hostPortSel && st_r.indexBits == IDX_CONFIG &&
        hostWrData[CFG_DEFAULTS]) begin
      st_nxt.cfg = CONFIG_RST;
      st_nxt.statOne = STAT_RST;
      st_nxt.statTwo = STAT_RST;
      st_nxt.smaskOne = MASK_RST;
      st_nxt.smaskTwo = MASK_RST;
      st_nxt.hmaskOne = MASK_RST;
      st_nxt.hmaskTwo = HMASK_TWO_RST;
      st_nxt.fanDiv = FAN_DIV_RST;
      st_nxt.capturePtr = 5'h00;
      st_nxt.captureFull = 1'b0;
    end

    // interrupt pins: enable, pending unmasked status, clear bit overrides
    st_nxt.smiOut_n = !(st_r.cfg[CFG_SMI_EN] && !st_r.cfg[CFG_IRQ_CLR] &&
      (|(st_r.statOne & ~st_r.smaskOne) ||
       |(st_r.statTwo[6:0] & ~st_r.smaskTwo[6:0])));
    st_nxt.hostOut_n = !(st_r.cfg[CFG_HOST_EN] && !st_r.cfg[CFG_IRQ_CLR] &&
      (|(st_r.statOne & ~st_r.hmaskOne) ||
       |(st_r.statTwo[6:0] & ~st_r.hmaskTwo[6:0])));
    st_nxt.nmiSel = st_r.cfg[CFG_NMI_SEL];
    st_nxt.bypassOe = st_r.cfg[CFG_BYPASS];
    st_nxt.run = st_r.cfg[CFG_START] &&
                 !st_r.cfg[CFG_IRQ_CLR];

    // power-on state; RAM contents are not cleared
    if (sys_rst) begin
      st_nxt.indexBits = INDEX_RST;
      st_nxt.busyByPtr = 1'b0;
      st_nxt.rdData = 8'h00;
      st_nxt.cfg = CONFIG_RST;
      st_nxt.statOne = STAT_RST;
      st_nxt.statTwo = STAT_RST;
      st_nxt.smaskOne = MASK_RST;
      st_nxt.smaskTwo = MASK_RST;
      st_nxt.hmaskOne = MASK_RST;
      st_nxt.hmaskTwo = HMASK_TWO_RST;
      st_nxt.fanDiv = FAN_DIV_RST;
      st_nxt.slaveAddr = SLAVE_ADDR_RST;
      st_nxt.capturePtr = 5'h00;
      st_nxt.captureFull = 1'b0;
      st_nxt.pulseStarted = 1'b0;
      st_nxt.timerStart = 1'b0;
      st_nxt.resetOe = 1'b0;
      st_nxt.bypassOe = 1'b0;
      st_nxt.smiOut_n = 1'b1;
      st_nxt.hostOut_n = 1'b1;
      st_nxt.nmiSel = 1'b0;
      st_nxt.run = 1'b0;
    end
  end

  // -------------------------------------------------------------------------
  // register and outputs
  // -------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  // every output except the open-drain data lines is a state bit; those two are constant low
  assign hostRdData = st_r.rdData;
  assign monitorRun = st_r.run;
  assign serialSlaveAddr = st_r.slaveAddr;
  assign fanDivisor = st_r.fanDiv;
  assign sysMgmtInterruptOut_n = st_r.smiOut_n;
  assign hostIrqOut_n = st_r.hostOut_n;
  assign nmiSelect = st_r.nmiSel;
  assign resetPinOut = 1'b0;
  assign resetPinOe = st_r.resetOe;
  assign bypassPinOut = 1'b0;
  assign bypassPinOe = st_r.bypassOe;
endmodule : monitor_host_port_config

/* verification/monitor_host_port_config_checker.sv */
/*
  Checker: host strobes, read data and pins.
  Assumes binding into the top module, same clock.
*/
`timescale 1ns/1ns
module monitor_host_port_config_checker #(
  parameter longint RESET_CYCLES = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // host port
  input wire logic hostWrStb,
  input wire logic hostRdStb,
  input wire logic hostPortSel,
  input wire logic [7:0] hostWrData,
  input wire logic [7:0] hostRdData,
  input wire logic serialBusy,
  // pins
  input wire logic monitorRun,
  input wire logic nmiSelect,
  input wire logic sysMgmtInterruptOut_n,
  input wire logic hostIrqOut_n,
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  input wire logic bypassPinOut,
  input wire logic bypassPinOe
);
  // -----------------
  // pulse length
  // -----------------
  logic [31:0] pulseLen_r;
  // cycles with reset pin low
  always_ff @(posedge clk) begin
    if (sys_rst || !resetPinOe) pulseLen_r <= 32'h0;
    else pulseLen_r <= pulseLen_r + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // -----------------
  // properties
  // -----------------
  a_reset_quiet: assert property ($past(sys_rst) |->
    hostRdData == 8'h00 && !monitorRun && !nmiSelect && !resetPinOe
    && !bypassPinOe && sysMgmtInterruptOut_n && hostIrqOut_n)
    else $error("reset outputs");
  a_ptr_busy: assert property (
    hostWrStb && !hostPortSel ##2 hostRdStb && !hostPortSel
    |=> hostRdData == {1'b1, $past(hostWrData[6:0], 3)})
    else $error("pointer busy");
  a_serial_busy: assert property (
    hostRdStb && !hostPortSel && serialBusy |=> hostRdData[7])
    else $error("serial busy");
  a_busy_clear: assert property (
    (hostRdStb || hostWrStb) && hostPortSel && !serialBusy
    ##1 !hostWrStb && !serialBusy
    ##1 hostRdStb && !hostPortSel && !serialBusy |=> !hostRdData[7])
    else $error("busy kept");
  a_rd_hold: assert property (
    !$past(hostRdStb) |-> $stable(hostRdData))
    else $error("read data moved");
  a_pulse_len: assert property (
    $fell(resetPinOe) |-> pulseLen_r == RESET_CYCLES)
    else $error("pulse length");
  a_pulse_bound: assert property (
    resetPinOe |-> pulseLen_r < RESET_CYCLES)
    else $error("pulse too long");
  a_cfg_cause: assert property (
    $changed(nmiSelect) || $changed(bypassPinOe)
    |-> $past(hostWrStb) || $past(hostWrStb, 2))
    else $error("config pin moved");
  a_run_cause: assert property (
    !hostWrStb ##1 !hostWrStb |=> $stable(monitorRun))
    else $error("run moved");
  a_open_drain: assert property (
    !resetPinOut && !bypassPinOut)
    else $error("open drain high");
  c_pulse: cover property ($rose(resetPinOe));
  c_serial: cover property (hostRdStb && !hostPortSel && serialBusy);
  c_ptr: cover property (hostWrStb && !hostPortSel ##2 hostRdStb);
endmodule : monitor_host_port_config_checker

bind monitor_host_port_config monitor_host_port_config_checker #(
  .RESET_CYCLES(RESET_CYCLES)
) chk_u (
  .clk(clk), .sys_rst(sys_rst), .hostWrStb(hostWrStb),
  .hostRdStb(hostRdStb), .hostPortSel(hostPortSel),
  .hostWrData(hostWrData), .hostRdData(hostRdData),
  .serialBusy(serialBusy), .monitorRun(monitorRun),
  .nmiSelect(nmiSelect), .sysMgmtInterruptOut_n(sysMgmtInterruptOut_n),
  .hostIrqOut_n(hostIrqOut_n), .resetPinOut(resetPinOut),
  .resetPinOe(resetPinOe), .bypassPinOut(bypassPinOut),
  .bypassPinOe(bypassPinOe)
);

/* verification/host_bus_model.sv */
/*
  Host model for the host and capture ports.
  Assumes clk shared with the block.
*/
`timescale 1ns/1ns
module host_bus_model (
  // clock
  input wire logic clk,
  // host port
  output logic hostWrStb,
  output logic hostRdStb,
  output logic hostPortSel,
  output logic [7:0] hostWrData,
  input wire logic [7:0] hostRdData,
  // capture port
  output logic bootCodeWrStb,
  output logic [7:0] bootCodeData
);
  // idle bus at time zero
  initial begin
    {hostWrStb, hostRdStb, bootCodeWrStb, hostPortSel} = 4'h0;
    {hostWrData, bootCodeData} = 16'h0000;
  end
  // one access; idle lines inverted
  task automatic acc(input logic wr, sel, input logic [7:0] d,
                     output logic [7:0] v);
    @(posedge clk) #1;
    hostPortSel = sel;
    hostWrData = d;
    hostWrStb = wr;
    hostRdStb = !wr;
    @(posedge clk) #1;
    v = hostRdData;
    {hostWrStb, hostRdStb} = 2'h0;
    hostPortSel = !sel;
    hostWrData = ~d;
  endtask : acc
  // one capture-port write
  task automatic cap(input logic [7:0] d);
    @(posedge clk) #1;
    bootCodeData = d;
    bootCodeWrStb = 1'b1;
    @(posedge clk) #1;
    bootCodeWrStb = 1'b0;
    bootCodeData = ~d;
  endtask : cap
endmodule : host_bus_model

/* verification/monitor_host_port_config_tb.sv */
/*
  Bench for the monitor host port.
  Assumes one-cycle strobes from the host model.
*/
`timescale 1ns/1ns
module monitor_host_port_config_tb
  import monitor_host_port_pkg::*;
;
  localparam int RCYC = 20;
  localparam logic [4:0] VID = 5'h16;
  localparam logic [6:0] DEV_ID = 7'h33; // arbitrary value
  localparam logic [7:0] RV [10] = '{CONFIG_RST, STAT_RST, STAT_RST,
    MASK_RST, MASK_RST, MASK_RST, HMASK_TWO_RST, {FAN_DIV_RST, VID[3:0]},
    SLAVE_ADDR_RST, {DEV_ID, VID[4]}};
  localparam logic [6:0] IA [11] = '{7'h41, 7'h43, 7'h45, 7'h40, 7'h48,
    7'h1e, 7'h1f, 7'h7e, 7'h7f, 7'h20, 7'h3f};
  localparam logic [6:0] NA [11] = '{7'h42, 7'h44, 7'h46, 7'h40, 7'h48,
    7'h1f, 7'h1f, 7'h7f, 7'h7f, 7'h20, 7'h3f};
  logic clk, sys_rst, serialBusy, hostWrStb, hostRdStb, hostPortSel;
  logic bootCodeWrStb, monitorRun, sysMgmtInterruptOut_n, hostIrqOut_n;
  logic nmiSelect, resetPinOut, resetPinOe, bypassPinOut, bypassPinOe;
  logic [7:0] hostWrData, hostRdData, bootCodeData, serialSlaveAddr, v;
  logic [3:0] fanDiv;
  int n_fail, compares, cyc, k;

  monitor_host_port_config #(.RESET_CYCLES(RCYC), .DEVICE_ID(DEV_ID))
  dut_u (.clk(clk), .sys_rst(sys_rst), .hostWrStb(hostWrStb),
    .hostRdStb(hostRdStb), .hostPortSel(hostPortSel),
    .hostWrData(hostWrData), .hostRdData(hostRdData),
    .bootCodeWrStb(bootCodeWrStb), .bootCodeData(bootCodeData),
    .serialBusy(serialBusy), .statusSetOne(8'h00),
    .statusSetTwo(7'h00), .monitorRun(monitorRun),
    .serialSlaveAddr(serialSlaveAddr), .fanDivisor(fanDiv),
    .voltageIdPins(VID), .sysMgmtInterruptOut_n(sysMgmtInterruptOut_n),
    .hostIrqOut_n(hostIrqOut_n), .nmiSelect(nmiSelect),
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .bypassPinOut(bypassPinOut), .bypassPinOe(bypassPinOe));
  host_bus_model hb (.clk(clk), .hostWrStb(hostWrStb),
    .hostRdStb(hostRdStb), .hostPortSel(hostPortSel),
    .hostWrData(hostWrData), .hostRdData(hostRdData),
    .bootCodeWrStb(bootCodeWrStb), .bootCodeData(bootCodeData));

  // --------------
  // helpers
  // --------------
  task automatic check(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic pin(input string nm, input logic seen, exp);
    check(nm, {7'h00, seen}, {7'h00, exp});
  endtask : pin
  task automatic wr(input logic sel, input logic [7:0] d);
    hb.acc(1'b1, sel, d, v);
  endtask : wr
  task automatic rd(input logic sel);
    hb.acc(1'b0, sel, 8'h00, v);
  endtask : rd
  // index first, then the data access
  task automatic w(input logic [6:0] idx, input logic [7:0] d);
    wr(1'b0, {1'b0, idx});
    wr(1'b1, d);
  endtask : w
  task automatic r(input logic [6:0] idx, input logic [7:0] e);
    wr(1'b0, {1'b0, idx});
    rd(1'b1);
    check("data", v, e);
  endtask : r
  task automatic wc(input logic [7:0] d);
    w(IDX_CONFIG, d);
    repeat (3) @(posedge clk);
    #1;
  endtask : wc
  task automatic stop_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // --------------
  // clock, reset, timeout
  // --------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  // --------------
  // tests
  // --------------
  initial begin
    sys_rst = 1'b1;
    serialBusy = 1'b0;
    repeat (16) @(posedge clk);
    #1 sys_rst = 1'b0;
    rd(1'b0);
    check("ptr rst", v, {1'b0, INDEX_RST});
    for (int i = 0; i < 10; i++) begin
      r(IDX_CONFIG + 7'(i), RV[i]);
    end
    // pointer steps
    for (int i = 0; i < 11; i++) begin
      wr(1'b0, {1'b0, IA[i]});
      rd(1'b0);
      check("busy", v, {1'b1, IA[i]});
      rd(1'b1);
      rd(1'b0);
      check("step", v, {1'b0, NA[i]});
    end
    // capture port: own pointer
    wr(1'b0, 8'h30);
    for (int i = 0; i < 32; i++) hb.cap(8'(i));
    rd(1'b0);
    check("cap ptr", v, 8'hb0);
    wr(1'b0, 8'h00);
    for (int i = 0; i < 2; i++) begin
      rd(1'b1);
      check("cap ram", v, 8'(i));
    end
    wc(8'h03);
    pin("smi on", sysMgmtInterruptOut_n, 1'b0);
    wc(8'h02);
    pin("smi kept", sysMgmtInterruptOut_n, 1'b0);
    wc(8'h0e);
    pin("smi clr", sysMgmtInterruptOut_n, 1'b1);
    pin("host clr", hostIrqOut_n, 1'b1);
    wc(8'h04);
    pin("host on", hostIrqOut_n, 1'b0);
    pin("smi off", sysMgmtInterruptOut_n, 1'b1);
    r(IDX_STAT_TWO, 8'h20);
    // RAM steps hold at the end
    for (int i = 0; i < 2; i++) begin
      w(i ? 7'h7e : 7'h1e, 8'haa);
      wr(1'b1, 8'hbb);
      wr(1'b1, 8'hcc);
      wr(1'b0, i ? 8'h7e : 8'h1e);
      rd(1'b1);
      check("ram", v, 8'haa);
      rd(1'b1);
      check("ram hold", v, 8'hcc);
    end
    wc(8'h61);
    pin("nmi", nmiSelect, 1'b1);
    pin("bypass", bypassPinOe, 1'b1);
    pin("run", monitorRun, 1'b1);
    wc(8'h00);
    pin("irq", nmiSelect, 1'b0);
    pin("no bypass", bypassPinOe, 1'b0);
    pin("standby", monitorRun, 1'b0);
    // serial busy
    serialBusy = 1'b1;
    rd(1'b0);
    pin("ser busy", v[7], 1'b1);
    serialBusy = 1'b0;
    rd(1'b0);
    pin("ser done", v[7], 1'b0);
    // pulse needs enable
    wc(8'h10);
    pin("no pulse", resetPinOe, 1'b0);
    r(IDX_CONFIG, 8'h10);
    w(IDX_SMASK_TWO, 8'h80);
    k = 0;
    while (resetPinOe !== 1'b1 && k < 10) begin
      @(posedge clk) #1;
      k++;
    end
    k = 0;
    while (resetPinOe === 1'b1 && k < 100) begin
      @(posedge clk) #1;
      k++;
    end
    check("pulse", 8'(k), 8'(RCYC));
    r(IDX_CONFIG, 8'h00);
    // reload keeps slave address
    w(IDX_SLAVE_ADDR, 8'h55);
    w(IDX_FAN_DIV, 8'h90);
    w(IDX_CONFIG, 8'h80);
    r(IDX_CONFIG, CONFIG_RST);
    r(IDX_SMASK_TWO, MASK_RST);
    r(IDX_SLAVE_ADDR, 8'h55);
    check("slave", serialSlaveAddr, 8'h55);
    check("fan", {4'h0, fanDiv}, {4'h0, FAN_DIV_RST});
    // read-only, unmapped
    w(IDX_IDENT, 8'h00);
    r(IDX_IDENT, RV[9]);
    w(7'h4a, 8'hff);
    r(7'h4a, 8'h00);
    stop_test();
  end
endmodule : monitor_host_port_config_tb
